// ==== core/mpc_regs.svh ====
// register map, field positions and reset values of the pwm control block
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH
`define MPC_CON1_OFS 8'h00
`define MPC_CON2_OFS 8'h04
`define MPC_KEY_OFS 8'h08
`define MPC_DC1_OFS 8'h0c
`define MPC_DC2_OFS 8'h10
`define MPC_DC3_OFS 8'h14
`define MPC_PER_OFS 8'h18
`define MPC_OVD_OFS 8'h1c
`define MPC_PENL_LSB 0
`define MPC_PENH_LSB 4
`define MPC_SEV_LSB 8
`define MPC_IUE_BIT 2
`define MPC_OVERRIDE_SYNC_SELECT_BIT 1
`define MPC_BUFFER_UPDATE_DISABLE_BIT 0
`define MPC_CON1_MASK 16'h0077
`define MPC_CON2_MASK 16'h0f07
`define MPC_CON2_RST 16'h0000
`define MPC_KEY1 16'h5a5a
`define MPC_KEY2 16'ha5a5
`endif

// ==== core/mpc_pkg.sv ====
// types shared by the pwm control block
package mpc_pkg;
	typedef enum logic [1:0] {
		MPC_ULK_IDLE = 2'b00,
		MPC_ULK_KEY1 = 2'b01,
		MPC_ULK_OPEN = 2'b11
	} mpc_ulk_t;
	typedef logic [2:0] mpc_pen3_t;
endpackage

// ==== core/mpc_key_if.sv ====
// key and write strobes between register file and unlock tracker
`timescale 1ns/1ps
interface mpc_key_if;
	logic key_wr;
	logic [15:0] key_data;
	logic con1_wr;
	logic unlocked;
	modport regs (output key_wr, output key_data, output con1_wr,
		input unlocked);
	modport ulk (input key_wr, input key_data, input con1_wr,
		output unlocked);
endinterface

// ==== core/mpc_unlock.sv ====
// two-word key tracker that opens control register 1 for one write
`timescale 1ns/1ps
`include "mpc_regs.svh"
module mpc_unlock
	import mpc_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// strobes
	mpc_key_if.ulk kif
);
	mpc_ulk_t st_q;
	mpc_ulk_t st_d;
	wire key1_hit = kif.key_wr && (kif.key_data == `MPC_KEY1);
	wire key2_hit = kif.key_wr && (kif.key_data == `MPC_KEY2);

	// any stray key or a consumed write drops the sequence
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			MPC_ULK_IDLE:
				if (key1_hit) st_d = MPC_ULK_KEY1;
			MPC_ULK_KEY1:
				if (key2_hit) st_d = MPC_ULK_OPEN;
				else if (kif.key_wr || kif.con1_wr) st_d = MPC_ULK_IDLE;
			MPC_ULK_OPEN:
				if (key1_hit) st_d = MPC_ULK_KEY1;
				else if (kif.key_wr || kif.con1_wr) st_d = MPC_ULK_IDLE;
			default:
				st_d = MPC_ULK_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) st_q <= MPC_ULK_IDLE;
		else st_q <= st_d;
	end

	assign kif.unlocked = (st_q == MPC_ULK_OPEN);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_ULK_OPEN: assert property (
		$rose(kif.unlocked) |-> $past(key2_hit))
		else $error("unlock opened without second key");
	AST_ULK_USED: assert property (
		kif.con1_wr && !key1_hit |=> !kif.unlocked)
		else $error("unlock not consumed by write");
endmodule

// ==== core/mpc_postscaler.sv ====
// special event trigger postscaler
`timescale 1ns/1ps
module mpc_postscaler #(
	parameter int SW = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// event in, ratio select, trigger out
	input wire logic sev_match,
	input wire logic [SW-1:0] ratio_sel,
	output logic sev_trig
);
	logic [SW-1:0] cnt_q;
	logic trig_q;
	wire last = (cnt_q >= ratio_sel);

	// ratio n+1: trigger on match number n+1, then restart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= '0;
			trig_q <= 1'b0;
		end
		else
		begin
			trig_q <= sev_match && last;
			if (sev_match) cnt_q <= last ? '0 : cnt_q + 1'b1;
		end
	end

	assign sev_trig = trig_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PS_TRIG: assert property (
		sev_trig |-> $past(sev_match) && cnt_q == '0)
		else $error("trigger without match or restart");
	AST_PS_1TO1: assert property (
		ratio_sel == '0 && sev_match |=> sev_trig)
		else $error("ratio 1:1 missed a trigger");
	AST_PS_HOLD: assert property (
		sev_match && !last |=> !sev_trig)
		else $error("trigger before ratio reached");
	COV_PS_WRAP: cover property (sev_match && last && ratio_sel != '0);
endmodule

// ==== core/mpc_top.sv ====
// pwm pin enable, update and trigger control with apb registers
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "mpc_regs.svh"
module mpc_top
	import mpc_pkg::*;
#(
	parameter int DW = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration straps
	input wire logic write_lock_input,
	input wire logic pin_enable_reset_select,
	// time base events and waveforms
	input wire logic tb_sync,
	input wire logic sev_match,
	input wire logic [2:0] pwm_low,
	input wire logic [2:0] pwm_high,
	// output pins, oe low hands the pin to gpio
	output logic [2:0] low_output_pin,
	output logic [2:0] low_output_oe,
	output logic [2:0] high_output_pin,
	output logic [2:0] high_output_oe,
	// active values for the comparators, and the special event trigger
	output logic [3*DW-1:0] duty_active,
	output logic [DW-1:0] period_active,
	output logic [15:0] ovd_active,
	output logic sev_trig
);
	mpc_key_if kif();

	logic [15:0] con1_q;
	logic [15:0] con2_q;
	logic [DW-1:0] dc_buf_q [3];
	logic [DW-1:0] dc_act_q [3];
	logic [DW-1:0] per_buf_q;
	logic [DW-1:0] per_act_q;
	logic [15:0] ovd_q;
	logic [15:0] ovd_act_q;
	logic strap_done_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic pready_q;
	logic pslverr_q;
	logic [2:0] lo_pin_q;
	logic [2:0] lo_oe_q;
	logic [2:0] hi_pin_q;
	logic [2:0] hi_oe_q;

	// address decode
	wire setup = psel && !penable;
	wire wr = psel && penable && pready_q && pwrite;
	wire a_con1 = (paddr == `MPC_CON1_OFS);
	wire a_con2 = (paddr == `MPC_CON2_OFS);
	wire a_key = (paddr == `MPC_KEY_OFS);
	wire a_dc1 = (paddr == `MPC_DC1_OFS);
	wire a_dc2 = (paddr == `MPC_DC2_OFS);
	wire a_dc3 = (paddr == `MPC_DC3_OFS);
	wire a_per = (paddr == `MPC_PER_OFS);
	wire a_ovd = (paddr == `MPC_OVD_OFS);
	wire mapped = a_con1 || a_con2 || a_key || a_dc1 || a_dc2
		|| a_dc3 || a_per || a_ovd;
	wire [2:0] a_dc = {a_dc3, a_dc2, a_dc1};
	// a locked control register 1 write is dropped and flagged
	wire con1_open = !write_lock_input || kif.unlocked;
	wire con1_err = a_con1 && pwrite && !con1_open;
	wire con1_wr = wr && a_con1 && con1_open;
	wire immediate_update_enable = con2_q[`MPC_IUE_BIT];
	wire override_sync_select = con2_q[`MPC_OVERRIDE_SYNC_SELECT_BIT];
	wire buffer_update_disable = con2_q[`MPC_BUFFER_UPDATE_DISABLE_BIT];
	wire tb_xfer = tb_sync && !buffer_update_disable;
	wire [2:0] pen_l = con1_q[`MPC_PENL_LSB +: 3];
	wire [2:0] pen_h = con1_q[`MPC_PENH_LSB +: 3];
	wire [15:0] wd16 = pwdata[15:0];
	wire [DW-1:0] wd_dw = pwdata[DW-1:0];

	assign kif.key_wr = wr && a_key;
	assign kif.key_data = wd16;
	assign kif.con1_wr = con1_wr;

	mpc_unlock u_unlock (
		.pclk (pclk),
		.presetn (presetn),
		.kif (kif)
	);

	mpc_postscaler #(.SW(4)) u_post (
		.pclk (pclk),
		.presetn (presetn),
		.sev_match (sev_match),
		.ratio_sel (con2_q[`MPC_SEV_LSB +: 4]),
		.sev_trig (sev_trig)
	);

	// read mux; masks keep unimplemented bits at zero
	always_comb
	begin
		rd_d = '0;
		if (a_con1) rd_d[15:0] = con1_q & `MPC_CON1_MASK;
		else if (a_con2) rd_d[15:0] = con2_q & `MPC_CON2_MASK;
		else if (a_dc1) rd_d[DW-1:0] = dc_act_q[0];
		else if (a_dc2) rd_d[DW-1:0] = dc_act_q[1];
		else if (a_dc3) rd_d[DW-1:0] = dc_act_q[2];
		else if (a_per) rd_d[DW-1:0] = per_act_q;
		else if (a_ovd) rd_d[15:0] = ovd_q;
	end

	// no wait state: answer is ready in the first access phase cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end
		else
		begin
			pready_q <= setup;
			pslverr_q <= setup && (!mapped || con1_err);
			if (setup && !pwrite) prdata_q <= rd_d;
		end
	end

	// the strap is a level, so it is caught on the first edge after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strap_done_q <= 1'b0;
			con1_q <= '0;
		end
		else if (!strap_done_q)
		begin
			strap_done_q <= 1'b1;
			con1_q <= {9'h000, {3{~pin_enable_reset_select}}, 1'b0,
				{3{~pin_enable_reset_select}}};
		end
		else if (con1_wr) con1_q <= wd16 & `MPC_CON1_MASK;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) con2_q <= `MPC_CON2_RST;
		else if (wr && a_con2) con2_q <= wd16 & `MPC_CON2_MASK;
	end

	// immediate mode still respects the update disable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 3; i++)
			begin
				dc_buf_q[i] <= '0;
				dc_act_q[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (wr && a_dc[i]) dc_buf_q[i] <= wd_dw;
				if (wr && a_dc[i] && immediate_update_enable && !buffer_update_disable)
					dc_act_q[i] <= wd_dw;
				else if (tb_xfer && !immediate_update_enable)
					dc_act_q[i] <= dc_buf_q[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			per_buf_q <= '0;
			per_act_q <= '0;
		end
		else
		begin
			if (wr && a_per) per_buf_q <= wd_dw;
			if (tb_xfer) per_act_q <= per_buf_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovd_q <= '0;
			ovd_act_q <= '0;
		end
		else
		begin
			if (wr && a_ovd) ovd_q <= wd16;
			if (!override_sync_select || tb_sync) ovd_act_q <= ovd_q;
		end
	end

	// released pins drive low with oe off so the gpio mux owns them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lo_pin_q <= '0;
			lo_oe_q <= '0;
			hi_pin_q <= '0;
			hi_oe_q <= '0;
		end
		else
		begin
			lo_pin_q <= pwm_low & pen_l;
			lo_oe_q <= pen_l;
			hi_pin_q <= pwm_high & pen_h;
			hi_oe_q <= pen_h;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign low_output_pin = lo_pin_q;
	assign low_output_oe = lo_oe_q;
	assign high_output_pin = hi_pin_q;
	assign high_output_oe = hi_oe_q;
	assign duty_active = {dc_act_q[2], dc_act_q[1], dc_act_q[0]};
	assign period_active = per_act_q;
	assign ovd_active = ovd_act_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PIN_ROUTE: assert property (
		##1 low_output_pin == ($past(pwm_low) & $past(pen_l)))
		else $error("low pin not following enabled waveform");
	AST_PIN_REL: assert property (
		pen_l == 3'b000 |=> low_output_oe == 3'b000 && low_output_pin == '0)
		else $error("disabled low pin still driven");
	AST_LOCKED: assert property (
		wr && a_con1 && write_lock_input && !kif.unlocked
		|=> $stable(con1_q))
		else $error("locked register 1 was written");
	AST_FREE_WR: assert property (
		wr && a_con1 && !write_lock_input
		|=> con1_q == ($past(wd16) & `MPC_CON1_MASK))
		else $error("unlocked register 1 write lost");
	AST_PEN_RST: assert property (
		$rose(strap_done_q)
		|-> pen_l == {3{~$past(pin_enable_reset_select)}})
		else $error("pin enable reset value wrong");
	AST_IMM: assert property (
		wr && a_dc1 && immediate_update_enable && !buffer_update_disable |=> dc_act_q[0] == $past(wd_dw))
		else $error("immediate duty update missed");
	AST_SYNC_DC: assert property (
		!immediate_update_enable && !tb_sync |=> $stable(dc_act_q[0]) && $stable(dc_act_q[2]))
		else $error("duty changed off time base");
	AST_OVD_SYNC: assert property (
		override_sync_select && !tb_sync |=> $stable(ovd_act_q))
		else $error("override changed off time base");
	AST_OVD_NEXT: assert property (
		!override_sync_select |=> ovd_act_q == $past(ovd_q))
		else $error("override not applied next cycle");
	AST_CON2_ZERO: assert property (
		pready && !pwrite && a_con2 |-> prdata[15:12] == 4'h0
		&& prdata[7:3] == 5'h00 && prdata[31:16] == 16'h0000)
		else $error("unimplemented register 2 bits read nonzero");
	AST_BUFFER_UPDATE_DISABLE: assert property (
		buffer_update_disable |=> $stable(per_act_q) && $stable(dc_act_q[1]))
		else $error("transfer happened while disabled");
	COV_UNLOCK_WR: cover property (con1_wr && write_lock_input);
	COV_TB_XFER: cover property (tb_xfer && !immediate_update_enable);
	COV_OVD_SYNC: cover property (override_sync_select && tb_sync);
	COV_SEV: cover property (sev_trig);
endmodule

// ==== verif/test_pwm_pin_enable_update_ctrl.sv ====
// self-checking bench for the pwm pin enable and update control block
`timescale 1ns/1ps
`include "mpc_regs.svh"
module test_pwm_pin_enable_update_ctrl;
	typedef struct {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] r;
		logic e;
	} mpc_row_t;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic write_lock_input = 0;
	logic pin_enable_reset_select = 1;
	logic tb_sync = 0;
	logic sev_match = 0;
	logic [2:0] pwm_low = 3'h7;
	logic [2:0] pwm_high = 3'h2;
	logic [2:0] low_output_pin;
	logic [2:0] low_output_oe;
	logic [2:0] high_output_pin;
	logic [2:0] high_output_oe;
	logic [47:0] duty_active;
	logic [15:0] period_active;
	logic [15:0] ovd_active;
	logic sev_trig;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	int trig_cnt = 0;
	mpc_row_t rows[4];
	logic [3:0] ratios[3];

	mpc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .write_lock_input,
		.pin_enable_reset_select, .tb_sync, .sev_match, .pwm_low,
		.pwm_high, .low_output_pin, .low_output_oe, .high_output_pin,
		.high_output_oe, .duty_active, .period_active, .ovd_active,
		.sev_trig);

	initial
	begin
		forever #2.5 pclk = ~pclk;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			bad_count++;
			report_and_stop;
		end
	end

	// a one-cycle registered pulse is seen exactly once at mid-cycle
	always @(negedge pclk)
	begin
		if (sev_trig === 1'b1)
			trig_cnt++;
	end

	task report_and_stop;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// the answer is taken at the very edge that samples pready high;
	// only the hang guard ends a wait that never sees it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] rd;
		logic er;
		apb(1'b1, a, d, rd, er);
		chk("write error", 48'(ee), 48'(er));
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] x, input logic ee);
		logic [31:0] rd;
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		chk("read data", 48'(x), 48'(rd));
		chk("read error", 48'(ee), 48'(er));
	endtask

	task pulse(input logic s, input int k);
		repeat (k)
		begin
			@(posedge pclk);
			sev_match <= s;
			tb_sync <= ~s;
			@(posedge pclk);
			sev_match <= 1'b0;
			tb_sync <= 1'b0;
		end
	endtask

	task rst(input logic strap);
		@(posedge pclk);
		presetn <= 1'b0;
		pin_enable_reset_select <= strap;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		cyc(3);
	endtask

	initial
	begin
		int base;
		rows[0] = '{`MPC_CON2_OFS, 32'hffff_ffff, 32'h0f07, 1'b0};
		rows[1] = '{`MPC_CON2_OFS, 32'h0, 32'h0, 1'b0};
		rows[2] = '{`MPC_KEY_OFS, 32'h1234, 32'h0, 1'b0};
		rows[3] = '{8'h20, 32'hdead, 32'h0, 1'b1};
		ratios = '{4'h0, 4'h2, 4'hf};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		cyc(3);
		chk("low oe", 48'h0, 48'(low_output_oe));
		chk("high oe", 48'h0, 48'(high_output_oe));
		rdc(`MPC_CON1_OFS, 32'h0, 1'b0);
		rst(1'b0);
		chk("low oe", 48'h7, 48'(low_output_oe));
		chk("high pins", 48'h2, 48'(high_output_pin));
		rdc(`MPC_CON1_OFS, 32'h77, 1'b0);
		rdc(`MPC_CON2_OFS, 32'h0, 1'b0);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d, rows[i].e);
			rdc(rows[i].a, rows[i].r, rows[i].e);
		end
		write_lock_input <= 1'b1;
		wr(`MPC_CON1_OFS, 32'h3, 1'b1);
		rdc(`MPC_CON1_OFS, 32'h77, 1'b0);
		wr(`MPC_KEY_OFS, 32'h5a5a, 1'b0);
		wr(`MPC_KEY_OFS, 32'ha5a5, 1'b0);
		wr(`MPC_CON1_OFS, 32'h3, 1'b0);
		wr(`MPC_CON1_OFS, 32'h11, 1'b1);
		rdc(`MPC_CON1_OFS, 32'h3, 1'b0);
		write_lock_input <= 1'b0;
		wr(`MPC_CON1_OFS, 32'h5, 1'b0);
		rdc(`MPC_CON1_OFS, 32'h5, 1'b0);
		cyc(2);
		chk("low pins", 48'h5, 48'(low_output_pin));
		chk("low oe", 48'h5, 48'(low_output_oe));
		chk("high oe", 48'h0, 48'(high_output_oe));
		wr(`MPC_CON2_OFS, 32'h4, 1'b0);
		wr(`MPC_DC1_OFS, 32'h1111, 1'b0);
		cyc(2);
		chk("duty", 48'h1111, duty_active);
		wr(`MPC_CON2_OFS, 32'h0, 1'b0);
		wr(`MPC_DC2_OFS, 32'h2222, 1'b0);
		cyc(3);
		chk("duty", 48'h1111, duty_active);
		pulse(1'b0, 1);
		cyc(1);
		chk("duty", 48'h2222_1111, duty_active);
		wr(`MPC_CON2_OFS, 32'h1, 1'b0);
		wr(`MPC_DC3_OFS, 32'h3333, 1'b0);
		wr(`MPC_PER_OFS, 32'h4444, 1'b0);
		pulse(1'b0, 1);
		cyc(1);
		chk("duty", 48'h2222_1111, duty_active);
		chk("period", 48'h0, 48'(period_active));
		wr(`MPC_CON2_OFS, 32'h0, 1'b0);
		pulse(1'b0, 1);
		cyc(1);
		chk("duty", 48'h3333_2222_1111, duty_active);
		chk("period", 48'h4444, 48'(period_active));
		rdc(`MPC_PER_OFS, 32'h4444, 1'b0);
		wr(`MPC_OVD_OFS, 32'h00ff, 1'b0);
		cyc(2);
		chk("override", 48'h00ff, 48'(ovd_active));
		wr(`MPC_CON2_OFS, 32'h2, 1'b0);
		wr(`MPC_OVD_OFS, 32'h0f0f, 1'b0);
		cyc(3);
		chk("override", 48'h00ff, 48'(ovd_active));
		pulse(1'b0, 1);
		cyc(1);
		chk("override", 48'h0f0f, 48'(ovd_active));
		foreach (ratios[i])
		begin
			wr(`MPC_CON2_OFS, {20'h0, ratios[i], 8'h0}, 1'b0);
			base = trig_cnt;
			for (int r = 0; r < 2; r++)
			begin
				pulse(1'b1, int'(ratios[i]));
				cyc(2);
				chk("triggers", 48'(r), 48'(trig_cnt - base));
				pulse(1'b1, 1);
				cyc(2);
				chk("triggers", 48'(r + 1), 48'(trig_cnt - base));
			end
		end
		report_and_stop;
	end
endmodule
